// [logic/ctp_pkg.sv]
// package: register map, field positions, modes and output functions of the compact timer
package ctp_pkg;
   // ================================================================
   // register offsets (byte-wide registers on a plain port)
   localparam logic [2:0] ADDR_CTRL0 = 3'h0;
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] ADDR_CNT_LO = 3'h2;
   localparam logic [2:0] ADDR_CNT_HI = 3'h3;
   localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
   localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
   localparam logic [2:0] ADDR_PERIOD = 3'h6;
   localparam logic [2:0] ADDR_FLAGS = 3'h7;
   // ================================================================
   // control register 0 fields
   localparam int CTRL0_PAUSE = 7;
   localparam int CTRL0_ENABLE = 3;
   // control register 1 fields (timer_control_one)
   localparam int CTRL1_MODE_HI = 7;
   localparam int CTRL1_MODE_LO = 6;
   localparam int CTRL1_FUNC_HI = 5;
   localparam int CTRL1_FUNC_LO = 4;
   localparam int CTRL1_INIT = 3;
   localparam int CTRL1_INVERT = 2;
   localparam int CTRL1_SWAP = 1;
   localparam int CTRL1_CLRSEL = 0;
   // flag register fields, write one to clear
   localparam int FLAG_A = 0;
   localparam int FLAG_P = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   // ================================================================
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TIMER = 2'b11
   } ctp_mode_type;
   typedef enum logic [1:0] {
      FUNC_00 = 2'b00,
      FUNC_01 = 2'b01,
      FUNC_10 = 2'b10,
      FUNC_11 = 2'b11
   } ctp_func_type;
endpackage

// [logic/ctp_timer.sv]
// compact 16-bit timer with compare output, timer/counter and edge-aligned pwm modes
// Function
// - output_invert high inverts the pin; no effect in timer mode.
// - swap 0: period value sets period, compare A duty; swap 1 reversed.
// - clear_select 1 clears the counter on comparator A match.
// - clear_select 0 clears on P match, or overflow when period value zero.
// - pwm mode ignores clear_select completely.
// - counter readable as low and high read-only bytes, reset zero.
// - compare A held in low and high read/write bytes, reset zero.
// - period value matches counter bits 15..8; zero means 65536 clocks.
// - mode bits: 00 compare output, 10 pwm, 11 timer/counter.
// - compare mode, clear_select 0: both A and P flags raised on matches.
// - compare mode, clear_select 1: only the A flag, never P.
// - clear_select 1, compare A zero: overflow at FFFF, no A flag.
// - compare mode: pin changes only on comparator A match or enable rise.
// - compare mode: pin loads initial level on enable rise; func 00 no change.
// - timer mode counts and flags like compare mode, pin not driven.
// - pwm: one compare clears the counter, the other sets duty.
// - pwm: separate flag for comparator A and P matches.
// - pwm: initial bit picks active level, func forces or enables, invert reverses.
// - swap 0: period value times 256 (0 is 65536), duty >= period gives 100%.
// - swap 1: period from compare A, duty from period value times 256.
// - pwm counting and compares continue while output is forced.
// - enable rise zeroes counter and resets compare-mode pin; fall keeps count.
// - compare mode func: 00 none, 01 low, 10 high, 11 toggle.
// - pwm func: 00 inactive, 01 active, 10 waveform, 11 undefined.
module ctp_timer #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic count_tick,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic timer_output_pin,
   output logic timer_output_pin_oe_n,
   output logic match_a_flag,
   output logic match_p_flag,
   output logic [2:0] clock_select
);
   // ================================================================
   // registers
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [CNT_W-1:0] compare_a_value;
   logic [7:0] period_compare_value;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic enable_q;
   logic out_q;
   logic out_d;
   logic flag_a_q;
   logic flag_p_q;
   logic [7:0] rdata_q;

   logic timer_enable_bit;
   logic pause;
   logic output_invert;
   logic period_duty_swap;
   logic clear_select;
   logic output_initial_level;
   ctp_pkg::ctp_mode_type mode;
   ctp_pkg::ctp_func_type func;

   assign timer_enable_bit = ctrl0_q[ctp_pkg::CTRL0_ENABLE];
   assign pause = ctrl0_q[ctp_pkg::CTRL0_PAUSE];
   assign clock_select = ctrl0_q[6:4];
   assign mode = ctp_pkg::ctp_mode_type'({ctrl1_q[ctp_pkg::CTRL1_MODE_HI],
                                          ctrl1_q[ctp_pkg::CTRL1_MODE_LO]});
   assign func = ctp_pkg::ctp_func_type'({ctrl1_q[ctp_pkg::CTRL1_FUNC_HI],
                                          ctrl1_q[ctp_pkg::CTRL1_FUNC_LO]});
   assign output_initial_level = ctrl1_q[ctp_pkg::CTRL1_INIT];
   assign output_invert = ctrl1_q[ctp_pkg::CTRL1_INVERT];
   assign period_duty_swap = ctrl1_q[ctp_pkg::CTRL1_SWAP];
   assign clear_select = ctrl1_q[ctp_pkg::CTRL1_CLRSEL];

   // ================================================================
   // register writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl0_q <= ctp_pkg::RESET_BYTE;
         ctrl1_q <= ctp_pkg::RESET_BYTE;
         compare_a_value <= ctp_pkg::RESET_WORD;
         period_compare_value <= ctp_pkg::RESET_BYTE;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ctp_pkg::ADDR_CTRL0: ctrl0_q <= {reg_wdata[7:3], 3'h0};
            ctp_pkg::ADDR_CTRL1: ctrl1_q <= reg_wdata;
            ctp_pkg::ADDR_CMPA_LO: compare_a_value[7:0] <= reg_wdata;
            ctp_pkg::ADDR_CMPA_HI: compare_a_value[15:8] <= reg_wdata;
            ctp_pkg::ADDR_PERIOD: period_compare_value <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ================================================================
   // comparators
   logic tick;
   logic enable_rise;
   logic match_a;
   logic match_p;
   logic at_max;
   logic pwm_mode;
   logic [16:0] period_full;
   logic [16:0] duty_val;
   logic [16:0] period_val;

   assign enable_rise = timer_enable_bit & ~enable_q;
   assign tick = timer_enable_bit & ~pause & count_tick & ~enable_rise;
   assign pwm_mode = (mode == ctp_pkg::MODE_PWM);
   // period byte scales by 256; zero stands for a full 65536-clock span
   assign period_full = (period_compare_value == 8'h00) ? 17'h10000
                        : {1'b0, period_compare_value, 8'h00};
   // matches are taken on the count reached by this tick
   logic [CNT_W-1:0] count_inc;
   assign count_inc = count_q + 16'h0001;
   assign at_max = (count_q == ctp_pkg::COUNT_MAX);
   // zero compare A never matches: the incremented count only reaches zero through overflow
   assign match_a = tick && (compare_a_value != 16'h0000)
                    && (count_inc == compare_a_value);
   assign match_p = tick && (period_compare_value != 8'h00)
                    && (count_inc[15:8] == period_compare_value)
                    && (count_inc[7:0] == 8'h00);
   assign period_val = period_duty_swap ? {1'b0, compare_a_value} : period_full;
   assign duty_val = period_duty_swap ? period_full : {1'b0, compare_a_value};

   // ================================================================
   // counter
   always_comb begin
      count_d = count_q;
      if (enable_rise) begin
         count_d = '0;
      end else if (tick) begin
         count_d = count_inc;
         if (pwm_mode) begin
            // pwm period end, clear_select unused here
            if (period_duty_swap ? match_a : match_p) begin
               count_d = '0;
            end
         end else if (clear_select) begin
            if (match_a) begin
               count_d = '0;
            end
         end else if (match_p) begin
            count_d = '0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count_q <= ctp_pkg::RESET_WORD;
         enable_q <= 1'b0;
      end else begin
         count_q <= count_d;
         enable_q <= timer_enable_bit;
      end
   end

   // ================================================================
   // interrupt request flags; set wins over a same-cycle clear
   logic set_a;
   logic set_p;
   logic clr_a;
   logic clr_p;
   assign set_a = match_a;
   assign set_p = pwm_mode ? match_p : (match_p & ~clear_select);
   assign clr_a = reg_wr && (reg_addr == ctp_pkg::ADDR_FLAGS) && reg_wdata[ctp_pkg::FLAG_A];
   assign clr_p = reg_wr && (reg_addr == ctp_pkg::ADDR_FLAGS) && reg_wdata[ctp_pkg::FLAG_P];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else begin
         flag_a_q <= set_a | (flag_a_q & ~clr_a);
         flag_p_q <= set_p | (flag_p_q & ~clr_p);
      end
   end
   assign match_a_flag = flag_a_q;
   assign match_p_flag = flag_p_q;

   // ================================================================
   // output level (before polarity)
   logic pwm_active;
   // duty at or above period keeps the waveform active the whole period
   assign pwm_active = ({1'b0, count_d} < duty_val) || (duty_val >= period_val);

   always_comb begin
      out_d = out_q;
      unique case (mode)
         ctp_pkg::MODE_COMPARE: begin
            if (enable_rise) begin
               out_d = output_initial_level;
            end else if (match_a) begin
               unique case (func)
                  ctp_pkg::FUNC_00: out_d = out_q;
                  ctp_pkg::FUNC_01: out_d = 1'b0;
                  ctp_pkg::FUNC_10: out_d = 1'b1;
                  ctp_pkg::FUNC_11: out_d = ~out_q;
               endcase
            end
         end
         ctp_pkg::MODE_PWM: begin
            unique case (func)
               ctp_pkg::FUNC_00: out_d = ~output_initial_level;
               ctp_pkg::FUNC_01: out_d = output_initial_level;
               ctp_pkg::FUNC_10: out_d = pwm_active ? output_initial_level
                                                    : ~output_initial_level;
               ctp_pkg::FUNC_11: out_d = out_q;
            endcase
         end
         default: out_d = out_q;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         out_q <= 1'b0;
      end else begin
         out_q <= out_d;
      end
   end

   // timer/counter and undefined modes release the pin to other functions
   logic pin_q;
   logic oe_n_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         pin_q <= out_d ^ output_invert;
         oe_n_q <= (mode == ctp_pkg::MODE_TIMER) || (mode == ctp_pkg::MODE_UNDEF);
      end
   end
   assign timer_output_pin = pin_q;
   assign timer_output_pin_oe_n = oe_n_q;

   // ================================================================
   // read port, data in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= ctp_pkg::RESET_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ctp_pkg::ADDR_CTRL0: rdata_q <= ctrl0_q;
            ctp_pkg::ADDR_CTRL1: rdata_q <= ctrl1_q;
            ctp_pkg::ADDR_CNT_LO: rdata_q <= count_q[7:0];
            ctp_pkg::ADDR_CNT_HI: rdata_q <= count_q[15:8];
            ctp_pkg::ADDR_CMPA_LO: rdata_q <= compare_a_value[7:0];
            ctp_pkg::ADDR_CMPA_HI: rdata_q <= compare_a_value[15:8];
            ctp_pkg::ADDR_PERIOD: rdata_q <= period_compare_value;
            ctp_pkg::ADDR_FLAGS: rdata_q <= {6'h00, flag_p_q, flag_a_q};
         endcase
      end else begin
         rdata_q <= ctp_pkg::RESET_BYTE;
      end
   end
   assign reg_rdata = rdata_q;
endmodule

// [tb/ctp_timer_properties.sv]
// checker: port-level timing relations of the compact timer
module ctp_timer_properties (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic count_tick,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic timer_output_pin,
   input wire logic timer_output_pin_oe_n,
   input wire logic match_a_flag,
   input wire logic match_p_flag,
   input wire logic [2:0] clock_select
);
   // ==========
   // shadow of control register 1, taken from bus writes
   logic [7:0] c1_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) c1_q <= 8'h00;
      else if (reg_wr && reg_addr == 3'h1) c1_q <= reg_wdata;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   AST_TIMER_OE: assert property ((c1_q[7:6] == 2'b11) [*2] |-> timer_output_pin_oe_n)
      else $error("pin driven in timer mode");
   AST_CMP_OE: assert property ((c1_q[7:6] == 2'b00) [*2] |-> !timer_output_pin_oe_n)
      else $error("pin not driven in compare mode");
   AST_A_STICKY: assert property (match_a_flag && !(reg_wr && reg_addr == 3'h7
      && reg_wdata[0]) |=> match_a_flag)
      else $error("flag A dropped");
   AST_P_STICKY: assert property (match_p_flag && !(reg_wr && reg_addr == 3'h7
      && reg_wdata[1]) |=> match_p_flag)
      else $error("flag P dropped");
   AST_A_CLEAR: assert property (reg_wr && reg_addr == 3'h7 && reg_wdata[0] && !count_tick
      |=> !match_a_flag)
      else $error("flag A not cleared");
   AST_A_TICK: assert property ($rose(match_a_flag) |-> $past(count_tick))
      else $error("flag A without count tick");
   AST_NO_P: assert property ($rose(match_p_flag) |-> !($past(c1_q[0])
      && $past(c1_q[7:6]) != 2'b10))
      else $error("flag P with clear on A");
endmodule
bind ctp_timer ctp_timer_properties i_props (.core_clk, .sys_rst, .count_tick, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_output_pin, .timer_output_pin_oe_n,
   .match_a_flag, .match_p_flag, .clock_select);

// [tb/ctp_timer_tb.sv]
// testbench: registers, counting, flags and pin of the compact timer
module ctp_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic count_tick = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic timer_output_pin;
   logic timer_output_pin_oe_n;
   logic match_a_flag;
   logic match_p_flag;
   logic [2:0] clock_select;
   logic [31:0] lfsr = 32'h8EAC4BF5;
   // {control 1, period}; last entry runs with compare A at zero
   logic [15:0] cfg [11] = '{16'h3001, 16'h3D01, 16'h1800, 16'h2402, 16'hF101, 16'hA801,
      16'hA902, 16'hA600, 16'h9801, 16'h8801, 16'h3101};
   int errors = 0;
   int comparisons = 0;
   ctp_timer i_dut (.core_clk, .sys_rst, .count_tick, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .timer_output_pin, .timer_output_pin_oe_n, .match_a_flag,
      .match_p_flag, .clock_select);
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // ==========
   // reference: counter, flags and pin after n ticks from a fresh enable
   function automatic logic [18:0] expect_run(logic [7:0] c1, logic [7:0] per,
      logic [15:0] ca, int n);
      logic [15:0] c, nx;
      logic af, pf, ma, mp, lvl, pwm, usea, act;
      logic [16:0] plen, dlen;
      c = 16'h0000;
      af = 1'b0;
      pf = 1'b0;
      lvl = c1[3];
      pwm = c1[7:6] == 2'b10;
      usea = pwm ? c1[1] : c1[0];
      for (int i = 0; i < n; i++) begin
         nx = c + 16'h0001;
         ma = ca != 16'h0000 && nx == ca;
         mp = per != 8'h00 && nx == {per, 8'h00} && !(usea && !pwm);
         af = af | ma;
         pf = pf | mp;
         if (ma && c1[5:4] != 2'b00) lvl = (c1[5:4] == 2'b11) ? !lvl : c1[5];
         c = ((usea && ma) || (!usea && mp)) ? 16'h0000 : nx;
      end
      plen = (per == 8'h00) ? 17'h10000 : {1'b0, per, 8'h00};
      dlen = {1'b0, ca};
      if (c1[1]) begin
         dlen = plen;
         plen = {1'b0, ca};
      end
      act = ({1'b0, c} < dlen) || (dlen >= plen);
      if (pwm) lvl = ((c1[5:4] == 2'b10) ? act : c1[4]) ~^ c1[3];
      return {lvl ^ c1[2], pf, af, c};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic ticks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         count_tick <= 1'b1;
      end
      @(posedge core_clk);
      count_tick <= 1'b0;
      #1;
   endtask
   task automatic summarize();
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      summarize();
   end
   initial begin
      logic [7:0] c1;
      logic [15:0] ca;
      logic [18:0] e;
      int n;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         if (a == 2 || a == 3) bus(3'(a), 8'(rnd()) | 8'h01, 1'b1);
         bus(3'(a), 8'h00, 1'b0);
         check(reg_rdata, 8'h00);
      end
      for (int i = 0; i < 11; i++) begin
         c1 = cfg[i][15:8];
         ca = (i == 10) ? 16'h0000 : 16'(rnd() % 600) + 16'h0001;
         n = 200 + int'(rnd() % 500);
         bus(3'h0, 8'h00, 1'b1);
         bus(3'h7, 8'h03, 1'b1);
         bus(3'h1, c1, 1'b1);
         bus(3'h4, ca[7:0], 1'b1);
         bus(3'h5, ca[15:8], 1'b1);
         bus(3'h6, cfg[i][7:0], 1'b1);
         bus(3'h1, 8'h00, 1'b0);
         check(reg_rdata, c1);
         bus(3'h5, 8'h00, 1'b0);
         check(reg_rdata, ca[15:8]);
         bus(3'h0, {1'b0, lfsr[2:0], 4'h8}, 1'b1);
         check(8'(clock_select), 8'(lfsr[2:0]));
         ticks(n);
         e = expect_run(c1, cfg[i][7:0], ca, n);
         check(8'(timer_output_pin_oe_n), 8'(c1[7:6] == 2'b11));
         if (c1[7:6] != 2'b11) check(8'(timer_output_pin), 8'(e[18]));
         check(8'({match_p_flag, match_a_flag}), 8'(e[17:16]));
         // odd runs stop by clearing enable, even runs by pausing: both must hold the count
         bus(3'h0, (i % 2 == 0) ? 8'h88 : 8'h00, 1'b1);
         ticks(5);
         bus(3'h2, 8'h00, 1'b0);
         check(reg_rdata, e[7:0]);
         bus(3'h3, 8'h00, 1'b0);
         check(reg_rdata, e[15:8]);
      end
      summarize();
   end
endmodule
